// ==== hdl/rtc_calendar_pkg.sv ====
// Function
// - hour BCD 1-12 or 0-23, read/write
// - minute BCD 0-59, tens 6-4, units 3-0
// - month BCD 1-12, tens bit 12
// - day limit 31/30/29/28 by month, leap
// - weekday base-7, 0 Sunday to 6 Saturday
// - year BCD 0-99, tens 7-4, units 3-0
// - flag sets on cause, write one clears
// - flags 15-12: regulation, stopwatch 1/10/100 Hz
// - flags 8-0: alarm, day down to 1/32 s
// - enable bit gates same-position flag
// - enables 15-12 gate regulation and stopwatch
// - 24h mode zeroes am/pm on write and on hour step
package rtc_calendar_pkg;

    localparam logic [7:0]  HOUR_MINUTE_OFFSET = 8'h00;
    localparam logic [7:0]  MONTH_DAY_OFFSET   = 8'h04;
    localparam logic [7:0]  YEAR_WEEKDAY_OFFSET = 8'h08;
    localparam logic [7:0]  IRQ_FLAGS_OFFSET   = 8'h0c;
    localparam logic [7:0]  IRQ_ENABLES_OFFSET = 8'h10;
    localparam logic [7:0]  CLOCK_CONTROL_OFFSET = 8'h14;

    localparam logic [15:0] HOUR_MINUTE_RESET  = 16'h1200;
    localparam logic [15:0] MONTH_DAY_RESET    = 16'h0101;
    localparam logic [15:0] YEAR_WEEKDAY_RESET = 16'h0000;
    localparam logic [15:0] IRQ_FLAGS_RESET    = 16'h0000;
    localparam logic [15:0] IRQ_ENABLES_RESET  = 16'h0000;
    localparam logic        TWENTY_FOUR_RESET  = 1'b0;

    // implemented flag and enable positions
    localparam logic [15:0] IRQ_BITS_MASK      = 16'hf1ff;
    localparam int          DAY_TICK_BIT       = 7;
    localparam int          HOUR_TICK_BIT      = 6;
    localparam int          MINUTE_TICK_BIT    = 5;
    localparam int          CONTROL_24H_BIT    = 0;
    localparam int          CONTROL_BUSY_BIT   = 1;

    localparam logic [7:0]  LAST_MINUTE        = 8'h59;
    localparam logic [7:0]  LAST_HOUR_24       = 8'h23;
    localparam logic [7:0]  HOUR_ELEVEN        = 8'h11;
    localparam logic [7:0]  HOUR_TWELVE        = 8'h12;
    localparam logic [7:0]  FIRST_HOUR_12      = 8'h01;
    localparam logic [7:0]  LAST_MONTH         = 8'h12;
    localparam logic [7:0]  LAST_YEAR          = 8'h99;
    localparam logic [2:0]  LAST_WEEKDAY       = 3'h6;

    typedef struct packed {
        logic       spare_hi;
        logic       am_pm_indicator;
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
        logic       spare_lo;
        logic [2:0] minute_tens;
        logic [3:0] minute_units;
    } hour_minute_type;

    typedef struct packed {
        logic [2:0] spare_hi;
        logic       month_tens;
        logic [3:0] month_units;
        logic [1:0] spare_lo;
        logic [1:0] day_tens;
        logic [3:0] day_units;
    } month_day_type;

    typedef struct packed {
        logic [4:0] spare;
        logic [2:0] weekday_count;
        logic [3:0] year_tens;
        logic [3:0] year_units;
    } year_weekday_type;

endpackage

// ==== hdl/rtc_calendar.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        minute_carry,
    input  wire logic [15:0] cause_pulse,
    output logic             clock_irq
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
        return r;
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        logic r;
        r = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                 : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        return r;
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m,
                                            input logic       leap);
        logic [7:0] r;
        unique case (m)
            8'h02:                      r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default:                    r = 8'h31;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] bcd_wrap(input logic [7:0] v,
                                            input logic [7:0] wrap_at,
                                            input logic [7:0] wrap_to);
        logic [7:0] r;
        r = (v == wrap_at) ? wrap_to : bcd_inc(v);
        return r;
    endfunction

    function automatic logic [2:0] week_inc(input logic [2:0] w);
        logic [2:0] r;
        r = (w == rtc_calendar_pkg::LAST_WEEKDAY) ? 3'h0 : w + 3'h1;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    rtc_calendar_pkg::hour_minute_type  hm;
    rtc_calendar_pkg::hour_minute_type  next_hm;
    rtc_calendar_pkg::month_day_type    md;
    rtc_calendar_pkg::month_day_type    next_md;
    rtc_calendar_pkg::year_weekday_type yw;
    rtc_calendar_pkg::year_weekday_type next_yw;
    logic [15:0] irq_flags;
    logic [15:0] next_irq_flags;
    logic [15:0] irq_enables;
    logic [15:0] next_irq_enables;
    logic        twenty_four_hour_select;
    logic        next_twenty_four_hour_select;
    // busy follows the minute carry by one cycle
    logic        clock_busy_flag;
    logic        next_clock_busy_flag;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_clock_irq;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        setup_phase;
    logic        write_take;
    logic        lo_lanes;
    logic        mapped;
    logic [15:0] wdata16;

    always_comb begin
        setup_phase = psel && !penable;
        // writes land on the access edge; unmapped ones are refused
        write_take  = psel && penable && pready && pwrite && !pslverr;
        lo_lanes    = pstrb[0] && pstrb[1];
        wdata16     = pwdata[15:0];
        unique case (paddr)
            rtc_calendar_pkg::HOUR_MINUTE_OFFSET,
            rtc_calendar_pkg::MONTH_DAY_OFFSET,
            rtc_calendar_pkg::YEAR_WEEKDAY_OFFSET,
            rtc_calendar_pkg::IRQ_FLAGS_OFFSET,
            rtc_calendar_pkg::IRQ_ENABLES_OFFSET,
            rtc_calendar_pkg::CLOCK_CONTROL_OFFSET: mapped = 1'b1;
            default:                                mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // calendar count-up

    logic [7:0] minute_now;
    logic [7:0] hour_now;
    logic [7:0] month_now;
    logic [7:0] day_now;
    logic [7:0] year_now;
    logic [7:0] minute_up;
    logic [7:0] hour_up;
    logic [7:0] month_up;
    logic [7:0] day_up;
    logic [7:0] year_up;
    logic       am_pm_up;
    logic       hour_step;
    logic       day_step;
    logic       month_step;
    logic       year_step;
    logic       leap_year;
    logic [7:0] day_limit;

    always_comb begin
        minute_now = {1'b0, hm.minute_tens, hm.minute_units};
        hour_now   = {2'b00, hm.hour_tens, hm.hour_units};
        month_now  = {3'b000, md.month_tens, md.month_units};
        day_now    = {2'b00, md.day_tens, md.day_units};
        year_now   = {yw.year_tens, yw.year_units};
        // carries ripple through every counter on the same edge
        hour_step  = minute_carry && minute_now == rtc_calendar_pkg::LAST_MINUTE;
        minute_up  = (minute_now == rtc_calendar_pkg::LAST_MINUTE) ? 8'h00
                   : bcd_inc(minute_now);
        day_step   = 1'b0;
        am_pm_up   = 1'b0;
        hour_up    = bcd_inc(hour_now);
        if (twenty_four_hour_select) begin
            if (hour_now == rtc_calendar_pkg::LAST_HOUR_24) begin
                hour_up  = 8'h00;
                day_step = hour_step;
            end
        end else begin
            // 12h: 11 to 12 flips am/pm, 12 wraps to 1
            am_pm_up = hm.am_pm_indicator;
            if (hour_now == rtc_calendar_pkg::HOUR_TWELVE) begin
                hour_up = rtc_calendar_pkg::FIRST_HOUR_12;
            end else if (hour_now == rtc_calendar_pkg::HOUR_ELEVEN) begin
                am_pm_up = !hm.am_pm_indicator;
                day_step = hour_step && hm.am_pm_indicator;
            end
        end
        leap_year  = is_leap(year_now);
        day_limit  = last_day(month_now, leap_year);
        month_step = day_step && day_now == day_limit;
        day_up     = bcd_wrap(day_now, day_limit, 8'h01);
        year_step  = month_step && month_now == rtc_calendar_pkg::LAST_MONTH;
        month_up   = bcd_wrap(month_now, rtc_calendar_pkg::LAST_MONTH,
                              8'h01);
        year_up    = bcd_wrap(year_now, rtc_calendar_pkg::LAST_YEAR,
                              8'h00);
    end

    ////////////////////////////////////////////////////////////////////////
    // next values

    always_comb begin
        next_hm                      = hm;
        next_md                      = md;
        next_yw                      = yw;
        next_twenty_four_hour_select = twenty_four_hour_select;
        next_irq_enables             = irq_enables;
        next_clock_busy_flag         = minute_carry;
        if (minute_carry) begin
            next_hm.minute_units = minute_up[3:0];
            next_hm.minute_tens  = minute_up[6:4];
        end
        if (hour_step) begin
            next_hm.hour_units      = hour_up[3:0];
            next_hm.hour_tens       = hour_up[5:4];
            next_hm.am_pm_indicator = am_pm_up;
        end
        if (day_step) begin
            next_md.day_units     = day_up[3:0];
            next_md.day_tens      = day_up[5:4];
            next_yw.weekday_count = week_inc(yw.weekday_count);
        end
        if (month_step) begin
            next_md.month_units = month_up[3:0];
            next_md.month_tens  = month_up[4];
        end
        if (year_step) begin
            next_yw.year_units = year_up[3:0];
            next_yw.year_tens  = year_up[7:4];
        end
        // software write wins over a count-up in the same cycle
        if (write_take && lo_lanes) begin
            unique case (paddr)
                rtc_calendar_pkg::HOUR_MINUTE_OFFSET: begin
                    next_hm          = wdata16;
                    next_hm.spare_hi = 1'b0;
                    next_hm.spare_lo = 1'b0;
                    if (twenty_four_hour_select) begin
                        next_hm.am_pm_indicator = 1'b0;
                    end
                end
                rtc_calendar_pkg::MONTH_DAY_OFFSET: begin
                    next_md          = wdata16;
                    next_md.spare_hi = 3'h0;
                    next_md.spare_lo = 2'h0;
                end
                rtc_calendar_pkg::YEAR_WEEKDAY_OFFSET: begin
                    next_yw       = wdata16;
                    next_yw.spare = 5'h00;
                end
                rtc_calendar_pkg::IRQ_ENABLES_OFFSET: begin
                    next_irq_enables =
                        wdata16 & rtc_calendar_pkg::IRQ_BITS_MASK;
                end
                rtc_calendar_pkg::CLOCK_CONTROL_OFFSET: begin
                    next_twenty_four_hour_select =
                        wdata16[rtc_calendar_pkg::CONTROL_24H_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags

    logic [15:0] flag_set;
    logic [15:0] flag_clear;

    always_comb begin
        flag_set = cause_pulse;
        flag_set[rtc_calendar_pkg::MINUTE_TICK_BIT] = minute_carry;
        flag_set[rtc_calendar_pkg::HOUR_TICK_BIT]   = hour_step;
        flag_set[rtc_calendar_pkg::DAY_TICK_BIT]    = day_step;
        flag_clear = (write_take && lo_lanes
                      && paddr == rtc_calendar_pkg::IRQ_FLAGS_OFFSET)
                   ? wdata16 : 16'h0000;
        // a cause in the clearing cycle stays set
        next_irq_flags = ((irq_flags & ~flag_clear) | flag_set)
                       & rtc_calendar_pkg::IRQ_BITS_MASK;
        next_clock_irq = |(next_irq_flags
                           & next_irq_enables);
    end

    ////////////////////////////////////////////////////////////////////////
    // read answer

    always_comb begin
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        // answer is registered: pready stands in the first access cycle
        if (setup_phase) begin
            next_pready  = 1'b1;
            next_pslverr = !mapped;
            next_prdata  = 32'h0000_0000;
            unique case (paddr)
                rtc_calendar_pkg::HOUR_MINUTE_OFFSET:
                    next_prdata[15:0] = hm;
                rtc_calendar_pkg::MONTH_DAY_OFFSET:
                    next_prdata[15:0] = md;
                rtc_calendar_pkg::YEAR_WEEKDAY_OFFSET:
                    next_prdata[15:0] = yw;
                rtc_calendar_pkg::IRQ_FLAGS_OFFSET:
                    next_prdata[15:0] = irq_flags;
                rtc_calendar_pkg::IRQ_ENABLES_OFFSET:
                    next_prdata[15:0] = irq_enables;
                rtc_calendar_pkg::CLOCK_CONTROL_OFFSET: begin
                    next_prdata[rtc_calendar_pkg::CONTROL_24H_BIT] =
                        twenty_four_hour_select;
                    next_prdata[rtc_calendar_pkg::CONTROL_BUSY_BIT] =
                        clock_busy_flag;
                end
                default: begin
                end
            endcase
        end else if (psel && penable && pready) begin
            // data falls back to zero once the access is over
            next_prdata = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calendar, mode and enable registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hm                      <= rtc_calendar_pkg::HOUR_MINUTE_RESET;
            md                      <= rtc_calendar_pkg::MONTH_DAY_RESET;
            yw                      <= rtc_calendar_pkg::YEAR_WEEKDAY_RESET;
            irq_enables             <= rtc_calendar_pkg::IRQ_ENABLES_RESET;
            twenty_four_hour_select <= rtc_calendar_pkg::TWENTY_FOUR_RESET;
            clock_busy_flag         <= 1'b0;
        end else begin
            hm                      <= next_hm;
            md                      <= next_md;
            yw                      <= next_yw;
            irq_enables             <= next_irq_enables;
            twenty_four_hour_select <= next_twenty_four_hour_select;
            clock_busy_flag         <= next_clock_busy_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag and request registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags <= rtc_calendar_pkg::IRQ_FLAGS_RESET;
            clock_irq <= 1'b0;
        end else begin
            irq_flags <= next_irq_flags;
            clock_irq <= next_clock_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule
`default_nettype wire

// ==== tb/rtc_calendar_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        minute_carry,
    input wire logic [15:0] cause_pulse,
    input wire logic        clock_irq
);
    logic [15:0] en;
    logic [15:0] next_en;
    logic        h24;
    logic        next_h24;
    logic        clean;
    logic        next_clean;
    logic        wr;
    logic        rd;
    logic        en_wr;
    assign wr = psel && penable && pready && pwrite && pstrb[1:0] == 2'b11;
    assign rd = psel && penable && pready && !pwrite;
    assign en_wr = wr && paddr == 8'h10;
    // mirrors enables and hour mode for the irq and am/pm checks
    always_comb begin
        next_en = en;
        next_h24 = h24;
        next_clean = clean;
        if (en_wr)
            next_en = pwdata[15:0] & rtc_calendar_pkg::IRQ_BITS_MASK;
        if (wr && paddr == 8'h14) begin
            next_h24 = pwdata[0];
            next_clean = 1'b0;
        end
        if (wr && paddr == 8'h00 && h24)
            next_clean = 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= 16'h0000;
            h24 <= 1'b0;
            clean <= 1'b0;
        end else begin
            en <= next_en;
            h24 <= next_h24;
            clean <= next_clean;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_once;
        psel && !penable |=> pready && penable ##1 !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("pready not a single access cycle");
    property p_unmapped;
        psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_upper_zero;
        pready |-> prdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read data not zero");
    property p_hm_spare;
        rd && paddr == 8'h00 |-> !prdata[15] && !prdata[7];
    endproperty
    a_hm_spare: assert property (p_hm_spare)
        else $error("hour/minute reserved bit set");
    property p_md_spare;
        rd && paddr == 8'h04 |-> (prdata[15:0] & 16'he0c0) == 16'h0000;
    endproperty
    a_md_spare: assert property (p_md_spare)
        else $error("month/day reserved bit set");
    property p_weekday;
        rd && paddr == 8'h08 |-> prdata[15:11] == 5'h00 && prdata[10:8] <= 3'h6;
    endproperty
    a_weekday: assert property (p_weekday)
        else $error("weekday out of range");
    property p_irq_spare;
        rd && (paddr == 8'h0c || paddr == 8'h10)
            |-> (prdata[15:0] & ~rtc_calendar_pkg::IRQ_BITS_MASK) == 16'h0000;
    endproperty
    a_irq_spare: assert property (p_irq_spare)
        else $error("irq reserved bit set");
    property p_irq_on;
        ((|(cause_pulse & en & 16'hf11f)) || (minute_carry && en[5])) && !en_wr
            |=> clock_irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled cause gave no irq");
    property p_irq_off;
        en == 16'h0000 && !en_wr |=> !clock_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq with all enables clear");
    property p_ampm;
        rd && paddr == 8'h00 && h24 && clean |-> !prdata[14];
    endproperty
    a_ampm: assert property (p_ampm)
        else $error("am/pm set in 24h mode");
endmodule
bind rtc_calendar rtc_calendar_sva rtc_calendar_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .minute_carry(minute_carry), .cause_pulse(cause_pulse),
    .clock_irq(clock_irq));
`default_nettype wire

// ==== tb/test_rtc_calendar.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_rtc_calendar;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic        minute_carry = 1'b0;
    logic [15:0] cause_pulse = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clock_irq;
    logic [31:0] r;
    logic        e;
    int          n_fail = 0;
    int          checked = 0;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] d, x;} row_type;
    typedef struct packed {logic m; logic [15:0] hm, md, yw, eh, ed, ey, ef;} cu_type;
    row_type rows [13] = '{
        '{1'b0, 8'h00, 16'h0, rtc_calendar_pkg::HOUR_MINUTE_RESET},
        '{1'b0, 8'h04, 16'h0, rtc_calendar_pkg::MONTH_DAY_RESET},
        '{1'b0, 8'h08, 16'h0, rtc_calendar_pkg::YEAR_WEEKDAY_RESET},
        '{1'b0, 8'h0c, 16'h0, rtc_calendar_pkg::IRQ_FLAGS_RESET},
        '{1'b0, 8'h10, 16'h0, rtc_calendar_pkg::IRQ_ENABLES_RESET},
        '{1'b0, 8'h14, 16'h0, 16'h0000},
        '{1'b1, 8'h00, 16'h4159, 16'h4159}, '{1'b1, 8'h00, 16'hffff, 16'h7f7f},
        '{1'b1, 8'h04, 16'hffff, 16'h1f3f}, '{1'b1, 8'h08, 16'hfeff, 16'h06ff},
        '{1'b1, 8'h08, 16'h0599, 16'h0599}, '{1'b1, 8'h10, 16'hffff, 16'hf1ff},
        '{1'b1, 8'h0c, 16'h0000, 16'h0000}};
    cu_type cu [7] = '{
        '{1'b0, 16'h5159, 16'h0228, 16'h0623, 16'h1200, 16'h0301, 16'h0023, 16'he0},
        '{1'b0, 16'h5159, 16'h0228, 16'h0024, 16'h1200, 16'h0229, 16'h0124, 16'he0},
        '{1'b0, 16'h1159, 16'h0430, 16'h0000, 16'h5200, 16'h0430, 16'h0000, 16'h60},
        '{1'b0, 16'h5159, 16'h1231, 16'h0199, 16'h1200, 16'h0101, 16'h0200, 16'he0},
        '{1'b0, 16'h1259, 16'h0430, 16'h0000, 16'h0100, 16'h0430, 16'h0000, 16'h60},
        '{1'b0, 16'h0109, 16'h0430, 16'h0000, 16'h0110, 16'h0430, 16'h0000, 16'h20},
        '{1'b1, 16'h2359, 16'h0430, 16'h0399, 16'h0000, 16'h0501, 16'h0499, 16'he0}};
    always #50 pclk = ~pclk;
    rtc_calendar rtc_calendar_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .minute_carry(minute_carry), .cause_pulse(cause_pulse),
        .clock_irq(clock_irq));
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        apb(1'b0, a, 16'h0000);
        chk(r, {16'h0000, x});
    endtask
    task automatic pulse(input logic [15:0] c, input logic m);
        @(posedge pclk);
        cause_pulse <= c;
        minute_carry <= m;
        @(posedge pclk);
        cause_pulse <= 16'h0000;
        minute_carry <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        tally_and_finish();
    end
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w)
                apb(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].x);
        end
        apb(1'b0, 8'h18, 16'h0000);
        chk({31'h0, e}, 32'h1);
        pulse(16'hffff, 1'b0);
        chk({31'h0, clock_irq}, 32'h1);
        rd(8'h0c, 16'hf11f);
        apb(1'b1, 8'h0c, 16'h0001);
        rd(8'h0c, 16'hf11e);
        apb(1'b1, 8'h0c, 16'h0000);
        rd(8'h0c, 16'hf11e);
        apb(1'b1, 8'h0c, 16'hffff);
        rd(8'h0c, 16'h0000);
        chk({31'h0, clock_irq}, 32'h0);
        apb(1'b1, 8'h10, 16'h0000);
        pulse(16'h1000, 1'b0);
        chk({31'h0, clock_irq}, 32'h0);
        apb(1'b1, 8'h10, 16'h1000);
        @(negedge pclk);
        chk({31'h0, clock_irq}, 32'h1);
        apb(1'b1, 8'h0c, 16'h1000);
        @(negedge pclk);
        chk({31'h0, clock_irq}, 32'h0);
        foreach (cu[i]) begin
            apb(1'b1, 8'h14, {15'h0000, cu[i].m});
            apb(1'b1, 8'h0c, 16'hffff);
            apb(1'b1, 8'h00, cu[i].hm);
            apb(1'b1, 8'h04, cu[i].md);
            apb(1'b1, 8'h08, cu[i].yw);
            pulse(16'h0000, 1'b1);
            for (int k = 0; k < 8; k++) begin
                apb(1'b0, 8'h14, 16'h0000);
                if (r[1] !== 1'b1)
                    break;
            end
            rd(8'h00, cu[i].eh);
            rd(8'h04, cu[i].ed);
            rd(8'h08, cu[i].ey);
            rd(8'h0c, cu[i].ef);
        end
        apb(1'b1, 8'h00, 16'h4105);
        rd(8'h00, 16'h0105);
        pstrb <= 4'hc;
        apb(1'b1, 8'h04, 16'h0909);
        pstrb <= 4'hf;
        rd(8'h04, 16'h0501);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, rtc_calendar_pkg::HOUR_MINUTE_RESET);
        rd(8'h0c, 16'h0000);
        rd(8'h14, 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
